//--- src/spp_port.sv
`timescale 1ns/1ps
`include "spp_defines.svh"
module spp_port
(
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             ctrl_wr,
  input  wire spp_pkg::spp_ctrl_t ctrl_in,
  input  wire spp_pkg::spp_dir_t  pin_dir,
  input  wire logic             port_power_reduction_bit,
  input  wire logic             ss_out_val,
  input  wire logic             tx_wr,
  input  wire logic [7:0]       tx_data,
  input  wire logic             rx_rd,
  input  wire logic             status_rd,
  output logic [7:0]            rx_data,
  output spp_pkg::spp_status_t  status,
  output logic                  irq,
  input  wire logic             sck_i,
  output logic                  sck_o,
  output logic                  sck_oe,
  input  wire logic             mosi_i,
  output logic                  mosi_o,
  output logic                  mosi_oe,
  input  wire logic             miso_i,
  output logic                  miso_o,
  output logic                  miso_oe,
  input  wire logic             ss_n_i,
  output logic                  ss_n_o,
  output logic                  ss_n_oe
);
  import spp_pkg::*;

  spp_ctrl_t   ctrl;
  spp_mstate_t state;
  logic [6:0]  half_cnt;
  logic [6:0]  half_len;
  logic [4:0]  edge_cnt;
  logic [3:0]  cnt_s;
  logic        busy_s;
  logic [7:0]  sr;
  logic [7:0]  next_sr;
  logic        data_o;
  logic        sck_s;
  logic        sck_q;
  logic        mosi_s;
  logic        miso_s;
  logic        ss_s;
  logic        ss_q;
  logic        armed;
  logic        next_flag;
  logic        next_wcol;

  // clock input sampled by the system clock in slave mode
  spp_sync u_sync_sck  (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(sck_i),
                        .reset_val(1'b0), .stable(sck_s));
  spp_sync u_sync_mosi (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(mosi_i),
                        .reset_val(1'b0), .stable(mosi_s));
  spp_sync u_sync_miso (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(miso_i),
                        .reset_val(1'b0), .stable(miso_s));
  spp_sync u_sync_ss   (.ref_clk(ref_clk), .rst_n(rst_n), .async_in(ss_n_i),
                        .reset_val(1'b1), .stable(ss_s));

  logic on;
  logic is_m;
  logic is_s;
  logic sel;
  logic mode_fault;
  logic tick;
  logic start_m;
  logic smp;
  logic stp;
  logic done_m;
  logic done_s;
  logic edge_s;
  logic lead_s;
  logic in_bit;
  logic out_bit;
  logic busy;

  assign on         = ctrl.enable & ~port_power_reduction_bit;
  assign is_m       = on & ctrl.master_select_bit;
  assign is_s       = on & ~ctrl.master_select_bit;
  assign sel        = ~ss_s;
  assign mode_fault = is_m & ~pin_dir.ss & sel;
  assign tick       = (state == SPP_M_RUN) & (half_cnt == 7'h01);
  assign start_m    = is_m & ~mode_fault & (state == SPP_M_IDLE) & tx_wr;
  assign edge_s     = is_s & sel & (sck_s != sck_q);
  assign lead_s     = (sck_q == ctrl.cpol);
  assign busy       = (state == SPP_M_RUN) | busy_s;

  // sample on leading edge for phase 0, trailing edge for phase 1
  assign smp = (tick & (edge_cnt[0] == ctrl.cpha)) | (edge_s & (lead_s != ctrl.cpha));
  assign stp = (tick & (edge_cnt[0] != ctrl.cpha)) | (edge_s & (lead_s == ctrl.cpha));
  assign done_m = tick & (edge_cnt == `SPP_LAST_EDGE);
  assign done_s = edge_s & (lead_s != ctrl.cpha) & (cnt_s == `SPP_LAST_BIT);
  assign in_bit  = ctrl.master_select_bit ? miso_s : mosi_s;
  assign out_bit = ctrl.bit_order_select ? sr[0] : sr[7];

  always_comb
  begin
    case ({ctrl.rate_select_high, ctrl.rate_select_low})
      2'b00:   half_len = `SPP_HALF_RATE0;
      2'b01:   half_len = `SPP_HALF_RATE1;
      2'b10:   half_len = `SPP_HALF_RATE2;
      default: half_len = `SPP_HALF_RATE3;
    endcase
    if (ctrl.double_speed_bit)
    begin
      half_len = half_len >> 1;
    end
  end

  always_comb
  begin
    next_sr = sr;
    if (smp)
    begin
      next_sr = ctrl.bit_order_select ? {in_bit, sr[7:1]} : {sr[6:0], in_bit};
    end
  end

  // control register; a mode fault drops master mode
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl <= '0;
    end
    else if (mode_fault)
    begin
      ctrl.master_select_bit <= 1'b0;
    end
    else if (ctrl_wr)
    begin
      ctrl <= ctrl_in;
    end
  end

  // master clock generator
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state    <= SPP_M_IDLE;
      half_cnt <= 7'h00;
      edge_cnt <= 5'h00;
      sck_o    <= 1'b0;
    end
    else
    begin
      case (state)
        SPP_M_IDLE:
        begin
          sck_o <= ctrl.cpol;
          if (start_m)
          begin
            state    <= SPP_M_RUN;
            half_cnt <= half_len;
            edge_cnt <= 5'h00;
          end
        end
        SPP_M_RUN:
        begin
          if (!is_m || mode_fault)
          begin
            state <= SPP_M_IDLE;
          end
          else if (tick)
          begin
            sck_o    <= ~sck_o;
            half_cnt <= half_len;
            edge_cnt <= edge_cnt + 5'h01;
            if (done_m)
            begin
              state <= SPP_M_IDLE;
            end
          end
          else
          begin
            half_cnt <= half_cnt - 7'h01;
          end
        end
        default:
        begin
          state <= SPP_M_IDLE;
        end
      endcase
    end
  end

  // slave bit counter, cleared whenever select is high
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_s  <= 4'h0;
      busy_s <= 1'b0;
      sck_q  <= 1'b0;
      ss_q   <= 1'b1;
    end
    else
    begin
      sck_q <= sck_s;
      ss_q  <= ss_s;
      if (!is_s || !sel)
      begin
        cnt_s  <= 4'h0;
        busy_s <= 1'b0;
      end
      else if (edge_s)
      begin
        busy_s <= ~done_s;
        if (lead_s != ctrl.cpha)
        begin
          cnt_s <= done_s ? 4'h0 : cnt_s + 4'h1;
        end
      end
    end
  end

  // shift register and serial output bit
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sr     <= `SPP_BYTE_RESET;
      data_o <= 1'b0;
    end
    else if (tx_wr && !busy && on)
    begin
      sr     <= tx_data;
      data_o <= ctrl.bit_order_select ? tx_data[0] : tx_data[7];
    end
    else
    begin
      sr <= next_sr;
      if (stp)
      begin
        data_o <= out_bit;
      end
      else if (is_s && sel && ss_q)
      begin
        data_o <= out_bit;
      end
    end
  end

  // receive buffer loaded only at byte completion
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_data <= `SPP_BYTE_RESET;
    end
    else if (done_m || done_s)
    begin
      rx_data <= next_sr;
    end
  end

  // flags: status read arms, next data access clears, set wins
  always_comb
  begin
    next_flag = status.transfer_done_flag;
    next_wcol = status.write_collision;
    if (armed && (tx_wr || rx_rd))
    begin
      next_flag = 1'b0;
      next_wcol = 1'b0;
    end
    if (done_m || done_s || mode_fault)
    begin
      next_flag = 1'b1;
    end
    if (tx_wr && busy)
    begin
      next_wcol = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status <= '0;
      armed  <= 1'b0;
      irq    <= 1'b0;
    end
    else
    begin
      status.transfer_done_flag <= next_flag;
      status.write_collision    <= next_wcol;
      status.master_select_bit  <= mode_fault ? 1'b0 : ctrl_wr ? ctrl_in.master_select_bit
                                                             : ctrl.master_select_bit;
      status.busy               <= start_m | (busy & ~done_m & ~done_s);
      irq                       <= next_flag & ctrl.xfer_irq_enable;
      if (tx_wr || rx_rd)
      begin
        armed <= 1'b0;
      end
      else if (status_rd && (status.transfer_done_flag || status.write_collision))
      begin
        armed <= 1'b1;
      end
    end
  end

  // pin directions forced while enabled
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sck_oe  <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
      ss_n_oe <= 1'b0;
      ss_n_o  <= 1'b1;
    end
    else
    begin
      sck_oe  <= is_m & ~mode_fault & pin_dir.sck;
      mosi_oe <= is_m & ~mode_fault & pin_dir.mosi;
      ss_n_oe <= is_m & pin_dir.ss;
      miso_oe <= is_s & sel & pin_dir.miso;
      ss_n_o  <= ss_out_val;
    end
  end

  assign mosi_o = data_o;
  assign miso_o = data_o;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  a_start_runs: assert property (start_m |=> state == SPP_M_RUN && edge_cnt == 5'h00)
    else $error("master start did not enter run");
  a_done_master: assert property (done_m |=> state == SPP_M_IDLE && status.transfer_done_flag)
    else $error("master byte end did not stop and flag");
  a_irq_gate: assert property ($rose(status.transfer_done_flag)
                               && $past(ctrl.xfer_irq_enable) |-> irq)
    else $error("interrupt missing on done flag");
  a_irq_cause: assert property (irq |-> status.transfer_done_flag)
    else $error("interrupt without done flag");
  a_rx_capture: assert property ((done_m || done_s) |=> rx_data == $past(next_sr))
    else $error("receive buffer not loaded");
  a_miso_quiet: assert property (is_s && !sel |=> !miso_oe)
    else $error("miso driven while deselected");
  a_slave_clear: assert property (is_s && !sel |=> cnt_s == 4'h0 && !busy_s)
    else $error("slave logic not reset on deselect");
  a_wcol_set: assert property (tx_wr && busy |=> status.write_collision)
    else $error("write collision not flagged");
  a_fault_slave: assert property (mode_fault |=> !ctrl.master_select_bit
                                  && status.transfer_done_flag)
    else $error("mode fault did not demote master");
  a_master_miso: assert property (is_m ##1 is_m |-> !miso_oe)
    else $error("miso driven in master mode");
  a_sck_idle: assert property (state == SPP_M_IDLE |=> sck_o == $past(ctrl.cpol))
    else $error("serial clock not at idle level");

  c_master_byte: cover property (done_m);
  c_slave_byte:  cover property (done_s);
  c_mode_fault:  cover property (mode_fault);
  c_collision:   cover property (tx_wr && busy);

endmodule // spp_port

//--- src/spp_defines.svh
`ifndef SPP_DEFINES_SVH
`define SPP_DEFINES_SVH

// half-period lengths of the master serial clock, in system clock cycles
`define SPP_HALF_RATE0  7'h02
`define SPP_HALF_RATE1  7'h08
`define SPP_HALF_RATE2  7'h20
`define SPP_HALF_RATE3  7'h40

// edges in one byte and the last edge index / bit index
`define SPP_LAST_EDGE   5'h0f
`define SPP_LAST_BIT    4'h7

// reset values
`define SPP_BYTE_RESET  8'h00

`endif

//--- src/spp_pkg.sv
package spp_pkg;

  // software control bits, double_speed_bit held alongside
  typedef struct packed {
    logic       xfer_irq_enable;
    logic       enable;
    logic       bit_order_select;
    logic       master_select_bit;
    logic       cpol;
    logic       cpha;
    logic       rate_select_high;
    logic       rate_select_low;
    logic       double_speed_bit;
  } spp_ctrl_t;

  // software pin directions, 1 = output wanted
  typedef struct packed {
    logic       mosi;
    logic       miso;
    logic       sck;
    logic       ss;
  } spp_dir_t;

  typedef struct packed {
    logic       transfer_done_flag;
    logic       write_collision;
    logic       master_select_bit;
    logic       busy;
  } spp_status_t;

  typedef enum logic [1:0] {
    SPP_M_IDLE = 2'b01,
    SPP_M_RUN  = 2'b10
  } spp_mstate_t;

endpackage

//--- src/spp_sync.sv
`timescale 1ns/1ps
module spp_sync
(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  input  wire logic reset_val,
  output logic      stable
);

  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end
    else
    begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a change is taken once the second and third stage agree
  logic seeded;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stable <= 1'b0;
      seeded <= 1'b0;
    end
    else if (!seeded)
    begin
      stable <= reset_val;
      seeded <= 1'b1;
    end
    else if (s2 == s3)
    begin
      stable <= s3;
    end
  end

endmodule // spp_sync

//--- dv/spp_slave_model.sv
`timescale 1ns/1ps
module spp_slave_model
(
  input  wire logic       sck,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsb,
  input  wire logic [7:0] tx,
  output logic            miso,
  output logic [7:0]      rx
);
  int n;
  function automatic logic pick(input int i);
    return lsb ? tx[i] : tx[7-i];
  endfunction
  initial
  begin
    n = 0;
    miso = 1'b0;
    rx = 8'h00;
  end
  always @(negedge ss_n)
  begin
    n = 0;
    if (!cpha)
      miso = pick(0);
  end
  // released line shows the inverse of its last value
  always @(posedge ss_n)
    miso = ~miso;
  always @(sck)
  begin
    if (!ss_n && n < 8)
    begin
      if ((sck != cpol) ^ cpha)
      begin
        rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
        n = n + 1;
      end
      else if (n > 0 || cpha)
        miso = pick(n);
    end
  end
endmodule // spp_slave_model

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import spp_pkg::*;
  logic        ref_clk, rst_n, ctrl_wr, port_power_reduction_bit, ss_out_val;
  logic        tx_wr, rx_rd, status_rd, irq, b_sck, b_mosi, b_ss, p_miso, last;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
  logic [7:0]  tx_data, rx_data, p_tx, p_rx, d, got;
  spp_ctrl_t   c, ctrl;
  spp_dir_t    pin_dir;
  spp_status_t status;
  int          seed, n_mismatch, samples_checked, n_edge, gap, run, e0, h;
  wire logic sck_w  = sck_oe ? sck_o : b_sck;
  wire logic mosi_w = mosi_oe ? mosi_o : b_mosi;
  wire logic ss_w   = ss_n_oe ? ss_n_o : b_ss;
  wire logic miso_w = miso_oe ? miso_o : p_miso;
  wire logic p_ss   = ss_n_oe ? ss_n_o : 1'b1;

  spp_port DUT (.ref_clk, .rst_n, .ctrl_wr, .ctrl_in(ctrl), .pin_dir,
    .port_power_reduction_bit, .ss_out_val, .tx_wr, .tx_data, .rx_rd, .status_rd,
    .rx_data, .status, .irq, .sck_i(sck_w), .sck_o, .sck_oe, .mosi_i(mosi_w),
    .mosi_o, .mosi_oe, .miso_i(miso_w), .miso_o, .miso_oe, .ss_n_i(ss_w),
    .ss_n_o, .ss_n_oe);
  spp_slave_model PART (.sck(sck_w), .mosi(mosi_w), .ss_n(p_ss), .cpol(c.cpol),
    .cpha(c.cpha), .lsb(c.bit_order_select), .tx(p_tx), .miso(p_miso), .rx(p_rx));

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // half periods of the master serial clock
  always @(posedge ref_clk)
  begin
    last <= sck_o;
    run <= run + 1;
    if (sck_o !== last)
    begin
      n_edge <= n_edge + 1;
      gap <= run;
      run <= 1;
    end
  end
  task automatic cmp(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_cnt(input int g, input int e);
    samples_checked++;
    if (g != e)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  task automatic set_ctrl(input spp_ctrl_t v);
    @(posedge ref_clk) ctrl <= v;
    ctrl_wr <= 1'b1;
    @(posedge ref_clk) ctrl_wr <= 1'b0;
  endtask
  task automatic send(input logic [7:0] v);
    @(posedge ref_clk) tx_data <= v;
    tx_wr <= 1'b1;
    @(posedge ref_clk) tx_wr <= 1'b0;
  endtask
  task automatic clr;
    @(posedge ref_clk) status_rd <= 1'b1;
    @(posedge ref_clk) status_rd <= 1'b0;
    rx_rd <= 1'b1;
    @(posedge ref_clk) rx_rd <= 1'b0;
  endtask
  task automatic wait_flag;
    for (int k = 0; k < 3000 && status.transfer_done_flag !== 1'b1; k++)
      @(negedge ref_clk);
  endtask
  // bench as external master, mode 0, sck at a sixteenth of ref_clk
  task automatic bmaster(input logic [7:0] v, input int nb, output logic [7:0] q);
    q = 8'h00;
    @(posedge ref_clk) b_ss <= 1'b0;
    cyc(8);
    for (int k = 0; k < nb; k++)
    begin
      b_mosi <= v[7-k];
      cyc(8);
      q = {q[6:0], miso_w};
      b_sck <= 1'b1;
      cyc(8);
      b_sck <= 1'b0;
    end
    cyc(8);
  endtask
  function automatic int hl(input logic [1:0] r, input logic x);
    int t;
    t = (r == 2'b11) ? 64 : (2 << (2 * r));
    return x ? t / 2 : t;
  endfunction
  task automatic tally_and_finish;
    $display("checked=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    {rst_n, ctrl_wr, tx_wr, rx_rd, status_rd, b_sck, b_mosi, last} = '0;
    {ss_out_val, b_ss} = 2'b11;
    port_power_reduction_bit = 1'b0;
    {ctrl, c, tx_data, p_tx} = '0;
    pin_dir = 4'h0;
    {seed, n_mismatch, samples_checked, n_edge, gap, run} = '0;
    seed = 34865;
    cyc(8);
    rst_n <= 1'b1;
    cyc(5);
    @(negedge ref_clk);
    cmp({status, irq, sck_oe, mosi_oe, miso_oe}, 8'h00);
    cmp(rx_data, 8'h00);
    cmp({ss_n_oe, ss_n_o, sck_o}, 8'h02);
    @(posedge ref_clk) pin_dir <= 4'hb;
    port_power_reduction_bit <= 1'b1;
    c = '0;
    {c.enable, c.master_select_bit} = 2'b11;
    set_ctrl(c);
    send(8'h5a);
    cyc(2);
    @(negedge ref_clk);
    cmp({status, sck_oe, mosi_oe, ss_n_oe}, 8'h10);
    @(posedge ref_clk) port_power_reduction_bit <= 1'b0;
    for (int i = 0; i < 24; i++)
    begin
      c = '0;
      {c.enable, c.master_select_bit, c.xfer_irq_enable} = {2'b11, i[0]};
      {c.cpol, c.cpha, c.rate_select_high, c.rate_select_low} = 4'(i);
      c.double_speed_bit = i[4];
      c.bit_order_select = 1'($random(seed));
      d = (i < 2) ? {8{i[0]}} : 8'($random(seed));
      p_tx = 8'($random(seed));
      h = hl(i[1:0], i[4]);
      set_ctrl(c);
      @(posedge ref_clk) ss_out_val <= 1'b0;
      cyc(4);
      e0 = n_edge;
      send(d);
      @(negedge ref_clk);
      cmp({status.busy, status.master_select_bit}, 8'h03);
      if (i == 5)
      begin
        cyc(3);
        send(~d);
      end
      wait_flag;
      @(negedge ref_clk);
      cmp_cnt(n_edge - e0, 16);
      cmp_cnt(gap, h);
      cmp(sck_o, c.cpol);
      cmp(irq, c.xfer_irq_enable);
      cmp(ss_n_o, 1'b0);
      cmp(status.write_collision, i == 5);
      if (h >= 8)
      begin
        cmp(p_rx, d);
        cmp(rx_data, p_tx);
      end
      @(posedge ref_clk) ss_out_val <= 1'b1;
      clr;
      @(negedge ref_clk);
      cmp(status, 8'h02);
    end
    @(posedge ref_clk) pin_dir <= 4'ha;
    set_ctrl(c);
    @(posedge ref_clk) b_ss <= 1'b0;
    cyc(10);
    @(negedge ref_clk);
    cmp(status, 8'h08);
    cmp({sck_oe, mosi_oe}, 8'h00);
    @(posedge ref_clk) b_ss <= 1'b1;
    clr;
    @(posedge ref_clk) pin_dir <= 4'h4;
    c = '0;
    {c.enable, c.xfer_irq_enable} = 2'b11;
    set_ctrl(c);
    send(8'ha5);
    repeat (3)
    begin
      @(posedge ref_clk) b_sck <= 1'b1;
      cyc(8);
      b_sck <= 1'b0;
      cyc(8);
    end
    @(negedge ref_clk);
    cmp({miso_oe, status.transfer_done_flag}, 8'h00);
    bmaster(8'h3c, 8, got);
    cmp(got, 8'ha5);
    @(negedge ref_clk);
    cmp({miso_oe, status.transfer_done_flag, irq}, 8'h07);
    cmp(rx_data, 8'h3c);
    @(posedge ref_clk) b_ss <= 1'b1;
    cyc(8);
    bmaster(8'hff, 3, got);
    @(posedge ref_clk) b_ss <= 1'b1;
    cyc(8);
    @(negedge ref_clk);
    cmp(rx_data, 8'h3c);
    bmaster(8'h96, 8, got);
    @(negedge ref_clk);
    cmp(rx_data, 8'h96);
    tally_and_finish;
  end
  initial
  begin
    cyc(90000);
    n_mismatch++;
    tally_and_finish;
  end
endmodule // testbench
